// ==== rtl/cps_serial_port.sv ====
// companded pcm serial port: link-side framing and core-side companding
// Contract
// - captured sample leaves in next frame
// - sign average subtracted from encoder input
// - eight-bit mu-law codes both directions
// - one conversion per frame strobe
// - fixed mode: eight consecutive master clocks
// - variable mode: eight own bit clocks
// - receive word captured in first eight bits
// - fixed mode transmit rising, receive sampled
// - variable mode repeats word while strobe high
// - strobe held low puts direction on standby
`timescale 1ns/1ns
`default_nettype none
module cps_serial_port
   import cps_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic master_clock,
   input wire logic tx_frame_strobe,
   input wire logic rx_frame_strobe,
   input wire logic tx_bit_clock,
   input wire logic rx_bit_clock,
   input wire logic pcm_in,
   output logic pcm_out,
   output logic pcm_out_oe,
   output logic tx_slot_indicator_n,
   input wire cps_lin_t tx_sample,
   input wire logic tx_sample_valid,
   output logic tx_sample_ready,
   output cps_lin_t rx_sample,
   output logic rx_sample_valid,
   input wire logic rx_sample_ready,
   output cps_status_t status
);
   // ***********************************************
   // link domain: reset, synchronisers, edges
   // ***********************************************
   logic lrst_meta;
   logic lrst_n;
   cps_link_in_t l_raw;
   cps_link_in_t l_meta;
   cps_link_in_t l_sync;
   cps_link_in_t l_prev;
   logic tx_post;
   logic tx_take;
   logic rx_post;
   logic fixed_mode;
   logic tx_standby;
   logic rx_standby;
   logic [5:0] watch;
   logic [9:0] tx_low;
   logic [9:0] rx_low;
   cps_code_t tx_code_hold;
   cps_code_t tx_next_code;
   logic [CODE_W-1:0] tx_shift;
   logic [CODE_W-1:0] tx_word;
   logic [3:0] tx_left;
   logic [CODE_W-1:0] rx_shift;
   logic [CODE_W-1:0] rx_hold;
   logic [3:0] rx_left;

   assign l_raw = '{tx_post: tx_post, pcm: pcm_in, rxclk: rx_bit_clock,
                    txclk: tx_bit_clock, rxfs: rx_frame_strobe, txfs: tx_frame_strobe};

   // two flops per foreign input; edges look only at the second and third
   always_ff @(posedge master_clock)
   begin
      lrst_meta <= reset_n;
      lrst_n <= lrst_meta;
      l_meta <= l_raw;
      l_sync <= l_meta;
      l_prev <= l_sync;
   end

   // edge and tick decode
   wire tx_rise = l_sync.txfs & ~l_prev.txfs;
   wire rx_rise = l_sync.rxfs & ~l_prev.rxfs;
   wire rx_clk_edge = l_sync.rxclk ^ l_prev.rxclk;
   wire tx_tick = fixed_mode | (l_sync.txclk & ~l_prev.txclk);
   wire rx_tick = fixed_mode | (~l_sync.rxclk & l_prev.rxclk);
   wire tx_post_evt = l_sync.tx_post ^ l_prev.tx_post;
   wire tx_repeat = ~fixed_mode & l_sync.txfs & pcm_out_oe;

   // ***********************************************
   // link domain: timing mode detection
   // ***********************************************
   // a bit clock never runs slower than fclk/32, so a longer silence
   // means the input is tied off and the master clock times the word
   always_ff @(posedge master_clock)
   begin
      if (!lrst_n)
      begin
         watch <= 6'h00;
         fixed_mode <= 1'h1;
      end
      else if (rx_clk_edge)
      begin
         watch <= 6'h00;
         fixed_mode <= 1'h0;
      end
      else if (watch != MODE_WATCH)
         watch <= watch + 6'h01;
      else
         fixed_mode <= 1'h1;
   end

   // ***********************************************
   // link domain: standby per direction
   // ***********************************************
   // a strobe low for a whole frame parks its direction
   always_ff @(posedge master_clock)
   begin
      if (!lrst_n)
      begin
         tx_low <= 10'h000;
         rx_low <= 10'h000;
         tx_standby <= 1'h0;
         rx_standby <= 1'h0;
      end
      else
      begin
         if (l_sync.txfs)
         begin
            tx_low <= 10'h000;
            tx_standby <= 1'h0;
         end
         else if (tx_low != STANDBY_CNT)
            tx_low <= tx_low + 10'h001;
         else
            tx_standby <= 1'h1;
         if (l_sync.rxfs)
         begin
            rx_low <= 10'h000;
            rx_standby <= 1'h0;
         end
         else if (rx_low != STANDBY_CNT)
            rx_low <= rx_low + 10'h001;
         else
            rx_standby <= 1'h1;
      end
   end

   // ***********************************************
   // link domain: transmit shifter
   // ***********************************************
   // the hold register is stable once its toggle is seen here
   always_ff @(posedge master_clock)
   begin
      if (!lrst_n)
         tx_next_code <= IDLE_CODE;
      else if (tx_post_evt)
         tx_next_code <= tx_code_hold;
   end

   // strobe rise loads last frame's code and asks the core for the next
   always_ff @(posedge master_clock)
   begin
      if (!lrst_n)
      begin
         tx_shift <= IDLE_CODE;
         tx_word <= IDLE_CODE;
         tx_left <= 4'h0;
         tx_take <= 1'h0;
         pcm_out <= 1'h0;
         pcm_out_oe <= 1'h0;
         tx_slot_indicator_n <= 1'h1;
      end
      else if (tx_rise)
      begin
         tx_shift <= tx_next_code;
         tx_word <= tx_next_code;
         tx_left <= BITS_PER_WORD;
         tx_take <= ~tx_take;
      end
      else if (tx_standby)
      begin
         tx_left <= 4'h0;
         pcm_out_oe <= 1'h0;
         tx_slot_indicator_n <= 1'h1;
      end
      else if (tx_tick)
      begin
         if (tx_left != 4'h0)
         begin
            pcm_out <= tx_shift[CODE_W-1];
            pcm_out_oe <= 1'h1;
            tx_slot_indicator_n <= 1'h0;
            tx_shift <= {tx_shift[CODE_W-2:0], 1'h0};
            tx_left <= tx_left - 4'h1;
         end
         else if (tx_repeat)
         begin
            pcm_out <= tx_word[CODE_W-1];
            tx_shift <= {tx_word[CODE_W-2:0], 1'h0};
            tx_left <= REPEAT_LEFT;
         end
         else
         begin
            pcm_out_oe <= 1'h0;
            tx_slot_indicator_n <= 1'h1;
         end
      end
   end

   // ***********************************************
   // link domain: receive shifter
   // ***********************************************
   // the hold word changes once a frame, long before the core reads it
   always_ff @(posedge master_clock)
   begin
      if (!lrst_n)
      begin
         rx_shift <= 8'h00;
         rx_hold <= IDLE_CODE;
         rx_left <= 4'h0;
         rx_post <= 1'h0;
      end
      else if (rx_rise)
         rx_left <= BITS_PER_WORD;
      else if (rx_standby)
         rx_left <= 4'h0;
      else if (rx_tick && rx_left != 4'h0)
      begin
         rx_shift <= {rx_shift[CODE_W-2:0], l_sync.pcm};
         rx_left <= rx_left - 4'h1;
         if (rx_left == 4'h1)
         begin
            rx_hold <= {rx_shift[CODE_W-2:0], l_sync.pcm};
            rx_post <= ~rx_post;
         end
      end
   end

   // ***********************************************
   // core domain: synchronisers and events
   // ***********************************************
   cps_core_in_t c_raw;
   cps_core_in_t c_meta;
   cps_core_in_t c_sync;
   cps_core_in_t c_prev;
   cps_lin_t txb_data;
   logic txb_valid;
   cps_code_t enc_code;
   cps_code_t rx_code;
   cps_lin_t dec_lin;
   logic rx_pend;
   logic rxb_ready;
   logic [AZ_W-1:0] az_acc;

   assign c_raw = '{tx_take: tx_take, rx_post: rx_post, fixed_mode: fixed_mode,
                    tx_standby: tx_standby, rx_standby: rx_standby};

   always_ff @(posedge clk)
   begin
      c_meta <= c_raw;
      c_sync <= c_meta;
      c_prev <= c_sync;
   end

   wire take_evt = c_sync.tx_take ^ c_prev.tx_take;
   wire rxp_evt = c_sync.rx_post ^ c_prev.rx_post;

   // ***********************************************
   // core domain: transmit encode with offset removal
   // ***********************************************
   cps_buf2 #(.WIDTH(LIN_W)) u_tx_buf (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(tx_sample),
      .in_valid(tx_sample_valid),
      .in_ready(tx_sample_ready),
      .out_data(txb_data),
      .out_valid(txb_valid),
      .out_ready(take_evt)
   );

   // an empty buffer at strobe time encodes silence instead of stalling
   wire cps_lin_t tx_pick = txb_valid ? txb_data : cps_lin_t'(0);
   wire cps_lin_t az_offset = cps_lin_t'(az_acc[AZ_W-1 -: LIN_W]);
   wire [LIN_W:0] az_diff = {tx_pick[LIN_W-1], tx_pick} - {az_offset[LIN_W-1], az_offset};
   wire az_ovf = az_diff[LIN_W] ^ az_diff[LIN_W-1];
   wire cps_lin_t enc_in = az_ovf ? {az_diff[LIN_W], {(LIN_W-1){~az_diff[LIN_W]}}}
                                  : cps_lin_t'(az_diff[LIN_W-1:0]);

   cps_mulaw u_mulaw (
      .enc_in(enc_in),
      .enc_out(enc_code),
      .dec_in(rx_code),
      .dec_out(dec_lin)
   );

   // one encode per take; the sign bit steers the long-term average
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         tx_code_hold <= IDLE_CODE;
         tx_post <= 1'h0;
         az_acc <= '0;
      end
      else if (take_evt)
      begin
         tx_code_hold <= enc_code;
         tx_post <= ~tx_post;
         az_acc <= enc_code.sign ? az_acc + AZ_STEP : az_acc - AZ_STEP;
      end
   end

   // ***********************************************
   // core domain: receive expand and buffer
   // ***********************************************
   // a new word in the same cycle as the push keeps the flag set
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         rx_code <= IDLE_CODE;
         rx_pend <= 1'h0;
      end
      else if (rxp_evt)
      begin
         rx_code <= rx_hold;
         rx_pend <= 1'h1;
      end
      else if (rxb_ready)
         rx_pend <= 1'h0;
   end

   cps_buf2 #(.WIDTH(LIN_W)) u_rx_buf (
      .clk(clk),
      .reset_n(reset_n),
      .in_data(dec_lin),
      .in_valid(rx_pend),
      .in_ready(rxb_ready),
      .out_data(rx_sample),
      .out_valid(rx_sample_valid),
      .out_ready(rx_sample_ready)
   );

   // status levels, one flop past the synchroniser
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         status <= '{fixed_mode: 1'h1, tx_standby: 1'h0, rx_standby: 1'h0};
      else
         status <= '{fixed_mode: c_sync.fixed_mode, tx_standby: c_sync.tx_standby,
                     rx_standby: c_sync.rx_standby};
   end

   // ***********************************************
   // assertions and covers
   // ***********************************************
   property p_fixed_eight;
      @(posedge master_clock) disable iff (!lrst_n)
      tx_rise && fixed_mode |=> ##1 pcm_out_oe [*8] ##1 !pcm_out_oe;
   endproperty
   a_fixed_eight: assert property (p_fixed_eight) else $error("fixed word not eight clocks");

   property p_next_frame;
      @(posedge master_clock) disable iff (!lrst_n)
      tx_rise |=> tx_shift == $past(tx_next_code);
   endproperty
   a_next_frame: assert property (p_next_frame) else $error("strobe did not load code");

   property p_msb_first;
      @(posedge master_clock) disable iff (!lrst_n)
      tx_rise && fixed_mode |-> ##2 pcm_out == $past(tx_shift[CODE_W-1]);
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("first bit not sign bit");

   property p_rx_word;
      @(posedge master_clock) disable iff (!lrst_n)
      rx_rise && fixed_mode && !rx_standby |-> ##9 $changed(rx_post);
   endproperty
   a_rx_word: assert property (p_rx_word) else $error("receive word not posted");

   property p_mode_detect;
      @(posedge master_clock) disable iff (!lrst_n)
      rx_clk_edge |=> !fixed_mode;
   endproperty
   a_mode_detect: assert property (p_mode_detect) else $error("bit clock seen yet fixed");

   property p_repeat;
      @(posedge master_clock) disable iff (!lrst_n)
      !tx_rise && !tx_standby && tx_tick && tx_left == 4'h0 && tx_repeat |=> tx_left == REPEAT_LEFT;
   endproperty
   a_repeat: assert property (p_repeat) else $error("word not repeated");

   property p_standby_quiet;
      @(posedge master_clock) disable iff (!lrst_n)
      tx_standby && !tx_rise |=> !pcm_out_oe && tx_slot_indicator_n;
   endproperty
   a_standby_quiet: assert property (p_standby_quiet) else $error("drive in standby");

   property p_bit_on_tick;
      @(posedge master_clock) disable iff (!lrst_n)
      !fixed_mode && $changed(pcm_out) |-> $past(tx_tick);
   endproperty
   a_bit_on_tick: assert property (p_bit_on_tick) else $error("bit moved off clock");

   property p_take_posts;
      @(posedge clk) disable iff (!reset_n)
      take_evt |=> $changed(tx_post) ##1 !$changed(tx_post);
   endproperty
   a_take_posts: assert property (p_take_posts) else $error("no single encode per take");

   property p_autozero;
      @(posedge clk) disable iff (!reset_n)
      take_evt && enc_code.sign |=> az_acc == $past(az_acc) + AZ_STEP;
   endproperty
   a_autozero: assert property (p_autozero) else $error("average not raised");

   c_fixed_word: cover property (@(posedge master_clock) disable iff (!lrst_n)
      tx_rise && fixed_mode ##10 !pcm_out_oe);
   c_repeat: cover property (@(posedge master_clock) disable iff (!lrst_n)
      tx_repeat && tx_tick && tx_left == 4'h0);
   c_rx_out: cover property (@(posedge clk) disable iff (!reset_n)
      rx_sample_valid && rx_sample_ready);
   c_standby: cover property (@(posedge master_clock) disable iff (!lrst_n)
      tx_standby && rx_standby);
endmodule
`default_nettype wire

// ==== rtl/cps_pkg.sv ====
// shared constants and carrier types of the companded pcm serial port
package cps_pkg;
   // word and sample geometry
   localparam int CODE_W = 8;
   localparam int LIN_W = 14;
   localparam logic [3:0] BITS_PER_WORD = 4'h8;
   localparam logic [3:0] REPEAT_LEFT = 4'h7;
   localparam logic [CODE_W-1:0] IDLE_CODE = 8'hFF;
   // link timing, in its own units, and derived link-clock counts
   localparam int LINK_PERIOD_NS = 160;
   localparam int FRAME_US = 125;
   localparam int FRAME_CYCLES = (FRAME_US * 1000 + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
   localparam logic [9:0] STANDBY_CNT = 10'(FRAME_CYCLES);
   localparam int BIT_CLOCK_DIV = 32;
   localparam logic [5:0] MODE_WATCH = 6'(BIT_CLOCK_DIV);
   // companding law
   localparam logic [12:0] MU_BIAS = 13'h0021;
   localparam logic [13:0] MU_CLIP = 14'h1FDE;
   localparam int CHORD_BASE = 5;
   // offset averaging accumulator
   localparam int AZ_W = 20;
   localparam logic [AZ_W-1:0] AZ_STEP = 20'h00001;
   // buffer
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef logic signed [LIN_W-1:0] cps_lin_t;

   typedef struct packed {
      logic sign;
      logic [2:0] chord;
      logic [3:0] step;
   } cps_code_t;

   typedef struct packed {
      logic fixed_mode;
      logic tx_standby;
      logic rx_standby;
   } cps_status_t;

   // pins and handshake toggles entering the link domain
   typedef struct packed {
      logic tx_post;
      logic pcm;
      logic rxclk;
      logic txclk;
      logic rxfs;
      logic txfs;
   } cps_link_in_t;

   // toggles and levels entering the core domain
   typedef struct packed {
      logic tx_take;
      logic rx_post;
      logic fixed_mode;
      logic tx_standby;
      logic rx_standby;
   } cps_core_in_t;
endpackage

// ==== rtl/cps_buf2.sv ====
// two-entry valid/ready buffer with registered head and flags
`timescale 1ns/1ns
`default_nettype none
module cps_buf2
   import cps_pkg::*;
#(
   parameter int WIDTH = LIN_W
)
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   logic [WIDTH-1:0] tail;
   logic [1:0] cnt;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;
   wire [1:0] next_cnt = cnt + {1'h0, push} - {1'h0, pop};

   // flags come from flops so the top outputs stay registered
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         cnt <= 2'h0;
         in_ready <= 1'h1;
         out_valid <= 1'h0;
         out_data <= '0;
         tail <= '0;
      end
      else
      begin
         cnt <= next_cnt;
         in_ready <= (next_cnt != BUF_DEPTH);
         out_valid <= (next_cnt != 2'h0);
         if (push && (cnt == 2'h0 || (cnt == 2'h1 && pop)))
            out_data <= in_data;
         else if (pop && cnt == BUF_DEPTH)
            out_data <= tail;
         if (push && cnt == 2'h1 && !pop)
            tail <= in_data;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/cps_mulaw.sv ====
// combinational mu-law compressor and expander
`timescale 1ns/1ns
`default_nettype none
module cps_mulaw
   import cps_pkg::*;
(
   input wire cps_lin_t enc_in,
   output cps_code_t enc_out,
   input wire cps_code_t dec_in,
   output cps_lin_t dec_out
);
   // highest set bit above the bias region picks the chord
   function automatic logic [2:0] chord_of(input logic [12:0] m);
      logic [2:0] c;
      c = 3'h0;
      for (int i = 1; i < 8; i++)
         if (m[i + CHORD_BASE])
            c = 3'(i);
      return c;
   endfunction

   // compress: magnitude, clip, bias, chord and step, then invert
   wire enc_neg = enc_in[LIN_W-1];
   wire [13:0] enc_abs = enc_neg ? 14'(-enc_in) : enc_in;
   wire [12:0] enc_clip = (enc_abs > MU_CLIP) ? MU_CLIP[12:0] : enc_abs[12:0];
   wire [12:0] enc_bias = enc_clip + MU_BIAS;
   wire [2:0] enc_chord = chord_of(enc_bias);
   wire [12:0] enc_shift = enc_bias >> ({1'h0, enc_chord} + 4'h1);
   assign enc_out = '{sign: ~enc_neg, chord: ~enc_chord, step: ~enc_shift[3:0]};

   // expand with the same law; result is in the compressor's scale
   wire [2:0] dec_chord = ~dec_in.chord;
   wire [12:0] dec_base = {8'h00, ~dec_in.step, 1'h0} + MU_BIAS;
   wire [12:0] dec_mag = (dec_base << dec_chord) - MU_BIAS;
   assign dec_out = dec_in.sign ? cps_lin_t'({1'h0, dec_mag}) : cps_lin_t'(-{1'h0, dec_mag});
endmodule
`default_nettype wire

// ==== verification/cps_far_end.sv ====
// far-end highway model: frame strobes, receive data and transmit capture
`timescale 1ns/1ns
`default_nettype none
module cps_far_end
(
   input wire logic master_clock,
   input wire logic pcm_out,
   input wire logic pcm_out_oe,
   input wire logic tx_slot_indicator_n,
   output logic tx_frame_strobe,
   output logic rx_frame_strobe,
   output logic tx_bit_clock,
   output logic rx_bit_clock,
   output logic pcm_in,
   output logic [7:0] seen_code,
   output logic [9:0] seen_oe,
   output logic [9:0] seen_slot,
   output logic seen_pulse
);
   // ****************************************
   // idle levels
   // ****************************************
   // receive bit clock tied low selects fixed mode
   initial
   begin
      rx_bit_clock = 1'b0;
      tx_bit_clock = 1'b0;
      tx_frame_strobe = 1'b0;
      rx_frame_strobe = 1'b0;
      pcm_in = 1'b0;
      seen_code = 8'h00;
      seen_oe = 10'h000;
      seen_slot = 10'h000;
      seen_pulse = 1'b0;
   end

   // ****************************************
   // one frame of the highway, fixed or variable rate
   // ****************************************
   // send rx_code sign first, capture the transmit slot; variable rate runs
   // both bit clocks at a quarter of the master clock and keeps the strobe
   // high past the word, so the slot repeats once
   task automatic frame(input logic [7:0] rx_code, input int period, input logic vr);
      logic [7:0] code;
      logic [9:0] oe;
      logic [9:0] slot;
      int e;
      int j;
      int r;
      code = 8'h00;
      oe = 10'h000;
      slot = 10'h000;
      e = vr ? 46 : 0;
      // pre-roll so the port has left fixed timing before the strobe
      if (vr)
         for (int p = 1; p <= 8; p++)
         begin
            @(negedge master_clock);
            tx_bit_clock = p[1];
            rx_bit_clock = p[1];
         end
      @(negedge master_clock);
      tx_frame_strobe = 1'b1;
      rx_frame_strobe = 1'b1;
      // first bit period follows the strobe; an early sample reads the inverse
      pcm_in = ~rx_code[7];
      for (int k = 1; k < period; k++)
      begin
         @(negedge master_clock);
         if (vr)
         begin
            tx_bit_clock = k[1];
            rx_bit_clock = k[1];
         end
         // sample every clock in fixed rate, on each bit-clock fall otherwise
         j = vr ? ((k % 4 == 0) ? k / 4 - 1 : -1) : k - 3;
         r = vr ? ((k % 4 == 2) ? (k - 2) / 4 : -1) : k - 1;
         if (j >= 0 && j <= 9)
         begin
            oe = {oe[8:0], pcm_out_oe};
            slot = {slot[8:0], tx_slot_indicator_n};
         end
         // an undriven line reads as the inverse of its last bit
         if (j >= 1 && j <= 8)
            code = {code[6:0], pcm_out ^ ~pcm_out_oe};
         // data moves on the bit-clock rise; stale bits toggle outside the word
         if (r >= 0 && r <= 7)
            pcm_in = rx_code[7 - r];
         else if (!vr || k % 4 == 2)
            pcm_in = ~pcm_in;
         if (k == 14 + e)
         begin
            seen_code = code;
            seen_oe = oe;
            seen_slot = slot;
            seen_pulse = 1'b1;
         end
         if (k == 15 + e)
            seen_pulse = 1'b0;
         if (k == 16 + e)
         begin
            tx_frame_strobe = 1'b0;
            rx_frame_strobe = 1'b0;
         end
      end
   endtask
endmodule
`default_nettype wire

// ==== verification/companded_pcm_serial_port_test.sv ====
// self-checking bench of the companded pcm serial port
`timescale 1ns/1ns
`default_nettype none
module companded_pcm_serial_port_test;
   import cps_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic master_clock = 1'b0;
   logic tx_frame_strobe, rx_frame_strobe, tx_bit_clock, rx_bit_clock, pcm_in;
   logic pcm_out, pcm_out_oe, tx_slot_indicator_n, seen_pulse;
   logic [7:0] seen_code;
   logic [9:0] seen_oe, seen_slot;
   cps_lin_t tx_sample = '0;
   cps_lin_t rx_sample;
   logic tx_sample_valid = 1'b0;
   logic tx_sample_ready, rx_sample_valid;
   logic rx_sample_ready = 1'b0;
   cps_status_t status;
   logic [7:0] tx_q[$];
   cps_lin_t rx_q[$];
   int n_fail = 0;
   int comparisons = 0;
   int tx_seen = 0;
   logic vr = 1'b0;

   // ****************************************
   // clocks, design and far end
   // ****************************************
   always #10 clk = ~clk;
   // odd start offset keeps the link clock out of phase with clk
   initial
   begin
      #37;
      forever #80 master_clock = ~master_clock;
   end

   cps_serial_port dut_u (.clk(clk), .reset_n(reset_n), .master_clock(master_clock),
      .tx_frame_strobe(tx_frame_strobe), .rx_frame_strobe(rx_frame_strobe),
      .tx_bit_clock(tx_bit_clock), .rx_bit_clock(rx_bit_clock), .pcm_in(pcm_in),
      .pcm_out(pcm_out), .pcm_out_oe(pcm_out_oe), .tx_slot_indicator_n(tx_slot_indicator_n),
      .tx_sample(tx_sample), .tx_sample_valid(tx_sample_valid),
      .tx_sample_ready(tx_sample_ready), .rx_sample(rx_sample),
      .rx_sample_valid(rx_sample_valid), .rx_sample_ready(rx_sample_ready), .status(status));

   cps_far_end far_u (.master_clock(master_clock), .pcm_out(pcm_out), .pcm_out_oe(pcm_out_oe),
      .tx_slot_indicator_n(tx_slot_indicator_n), .tx_frame_strobe(tx_frame_strobe),
      .rx_frame_strobe(rx_frame_strobe), .tx_bit_clock(tx_bit_clock),
      .rx_bit_clock(rx_bit_clock), .pcm_in(pcm_in), .seen_code(seen_code),
      .seen_oe(seen_oe), .seen_slot(seen_slot), .seen_pulse(seen_pulse));

   // ****************************************
   // helpers
   // ****************************************
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // mid-step linear value so a small offset correction keeps the code
   function automatic cps_lin_t mid_sample(logic neg, logic [2:0] ch, logic [3:0] st);
      int b;
      b = (1 << (ch + 5)) + (int'(st) << (ch + 1)) + (1 << ch) - 33;
      return neg ? cps_lin_t'(-b) : cps_lin_t'(b);
   endfunction

   function automatic cps_lin_t expand(logic [7:0] c);
      logic [7:0] u;
      int m;
      u = ~c;
      m = ((2 * int'(u[3:0]) + 33) << u[6:4]) - 33;
      return u[7] ? cps_lin_t'(-m) : cps_lin_t'(m);
   endfunction

   // offer one random sample at a falling edge, note its code
   task automatic push_random();
      logic neg;
      logic [2:0] ch;
      logic [3:0] st;
      int n;
      neg = 1'($urandom);
      ch = 3'(2 + $urandom % 6);
      st = 4'($urandom);
      tx_sample = mid_sample(neg, ch, st);
      tx_sample_valid = 1'b1;
      tx_q.push_back(~{neg, ch, st});
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (!(tx_sample_ready === 1'b1) && n < 2000);
      if (n >= 2000)
      begin
         check("push_timeout", 1, 0);
         results();
      end
      @(negedge clk);
   endtask

   // ****************************************
   // monitors
   // ****************************************
   // random stalls on the receive side
   always @(negedge clk)
      rx_sample_ready <= 1'($urandom);

   always @(posedge clk)
      if (reset_n && rx_sample_valid === 1'b1 && rx_sample_ready)
      begin
         if (rx_q.size() == 0)
            check("rx_extra", 1, 0);
         else
            check("rx_sample", rx_sample, rx_q.pop_front());
      end

   // first slot carries the reset idle code, so it is skipped
   always @(posedge master_clock)
      if (seen_pulse)
      begin
         tx_seen++;
         check("tx_oe", seen_oe, vr ? 10'h1FF : 10'h1FE);
         check("tx_slot", seen_slot, vr ? 10'h200 : 10'h201);
         if (tx_seen > 1 && tx_q.size() > 0)
            check("tx_code", seen_code, tx_q.pop_front());
      end

   initial
   begin
      #1000000;
      check("watchdog", 1, 0);
      results();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      logic [7:0] rc;
      void'($urandom(83));
      // reset must span link-clock edges as well as core edges
      repeat (5) @(posedge master_clock);
      @(negedge clk);
      reset_n = 1'b1;
      repeat (8) @(posedge master_clock);
      @(negedge clk);
      check("status_reset", status, 3'h4);
      // fill the two-entry buffer until it refuses
      push_random();
      push_random();
      tx_sample_valid = 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      check("tx_ready_full", tx_sample_ready, 0);
      for (int i = 0; i < 12; i++)
      begin
         // the last four frames run at variable rate
         vr = (i >= 8);
         rc = 8'($urandom);
         rx_q.push_back(expand(rc));
         far_u.frame(rc, vr ? 73 : 40, vr);
         @(negedge clk);
         push_random();
         tx_sample_valid = 1'b0;
      end
      repeat (200) @(negedge clk);
      check("tx_frames", tx_seen, 12);
      check("rx_left", rx_q.size(), 0);
      // both strobes low for longer than a frame
      repeat (800) @(negedge master_clock);
      repeat (10) @(negedge clk);
      check("status_standby", status, 3'h7);
      check("oe_standby", pcm_out_oe, 0);
      results();
   end
endmodule
`default_nettype wire
